/* rtl/eeprom_array_ecc.sv */
`timescale 1ns/1ps
`include "eeprom_array_ecc_consts.svh"

module eeprom_array_ecc (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     groupedMode,
  input  wire logic                     reqValid,
  input  wire logic                     reqWrite,
  input  wire logic [`EEA_ADDR_W-1:0]   reqAddr,
  input  wire logic [`EEA_BYTE_W-1:0]   reqData,
  output logic                          reqReady_q,
  output logic                          rdValid_q,
  output logic      [`EEA_BYTE_W-1:0]   rdData_q,
  output logic                          corrected_q,
  output logic                          arrRdReq_q,
  output logic                          arrWrReq_q,
  output logic      [`EEA_ROW_W-1:0]    arrAddr_q,
  output logic      [`EEA_BYTES-1:0]    arrByteEn_q,
  output logic      [`EEA_DATA_W-1:0]   arrWrData_q,
  output logic      [`EEA_CHK_W-1:0]    arrWrChk_q,
  input  wire logic                     arrAck,
  input  wire logic [`EEA_DATA_W-1:0]   arrRdData,
  input  wire logic [`EEA_CHK_W-1:0]    arrRdChk
);

  // ==========================================================
  // helpers
  function automatic logic [`EEA_BYTE_W-1:0] pickByte(
    input logic [`EEA_DATA_W-1:0] row,
    input logic [`EEA_LANE_W-1:0] lane
  );
    return row[lane*`EEA_BYTE_W +: `EEA_BYTE_W];
  endfunction

  function automatic logic [`EEA_DATA_W-1:0] putByte(
    input logic [`EEA_DATA_W-1:0] row,
    input logic [`EEA_LANE_W-1:0] lane,
    input logic [`EEA_BYTE_W-1:0] val
  );
    logic [`EEA_DATA_W-1:0] r;
    r = row;
    r[lane*`EEA_BYTE_W +: `EEA_BYTE_W] = val;
    return r;
  endfunction

  // ==========================================================
  // registers
  eeprom_array_ecc_pkg::state_t state_q;
  eeprom_array_ecc_pkg::state_t state_d;

  logic                     write_q;
  logic                     mode_q;
  logic [`EEA_LANE_W-1:0]   lane_q;
  logic [`EEA_BYTE_W-1:0]   data_q;
  logic [`EEA_DATA_W-1:0]   row_q;

  logic                     take;
  logic                     ackRd;
  logic                     ackWr;

  assign take  = (state_q == eeprom_array_ecc_pkg::IDLE) && reqValid && reqReady_q;
  assign ackRd = arrRdReq_q && arrAck;
  assign ackWr = arrWrReq_q && arrAck;

  // ==========================================================
  // decode of the array row and encode of the row buffer
  logic [`EEA_DATA_W-1:0]   gFix;
  logic                     gErr;
  logic [`EEA_DATA_W-1:0]   bFix;
  logic [`EEA_BYTES-1:0]    bErr;
  logic [`EEA_GCHK_W-1:0]   gEnc;
  logic [`EEA_CHK_W-1:0]    bEnc;
  logic [`EEA_DATA_W-1:0]   rowFix;
  logic                     rowErr;
  logic [`EEA_CHK_W-1:0]    encChk;

  hamming_sec #(
    .DW (`EEA_DATA_W),
    .CW (`EEA_GCHK_W)
  ) uGroupDec (
    .data        (arrRdData),
    .storedCheck (arrRdChk[`EEA_GCHK_W-1:0]),
    .check       (),
    .fixedData   (gFix),
    .error       (gErr)
  );

  hamming_sec #(
    .DW (`EEA_DATA_W),
    .CW (`EEA_GCHK_W)
  ) uGroupEnc (
    .data        (row_q),
    .storedCheck ('0),
    .check       (gEnc),
    .fixedData   (),
    .error       ()
  );

  for (genvar g = 0; g < `EEA_BYTES; g++) begin : gByte
    hamming_sec #(
      .DW (`EEA_BYTE_W),
      .CW (`EEA_BCHK_W)
    ) uDec (
      .data        (arrRdData[g*`EEA_BYTE_W +: `EEA_BYTE_W]),
      .storedCheck (arrRdChk[g*`EEA_BCHK_W +: `EEA_BCHK_W]),
      .check       (),
      .fixedData   (bFix[g*`EEA_BYTE_W +: `EEA_BYTE_W]),
      .error       (bErr[g])
    );

    hamming_sec #(
      .DW (`EEA_BYTE_W),
      .CW (`EEA_BCHK_W)
    ) uEnc (
      .data        (row_q[g*`EEA_BYTE_W +: `EEA_BYTE_W]),
      .storedCheck ('0),
      .check       (bEnc[g*`EEA_BCHK_W +: `EEA_BCHK_W]),
      .fixedData   (),
      .error       ()
    );
  end

  always_comb begin
    if (mode_q) begin
      rowFix = gFix;
      rowErr = gErr;
      encChk = {{(`EEA_CHK_W-`EEA_GCHK_W){1'b0}}, gEnc};
    end else begin
      rowFix = bFix;
      rowErr = bErr[lane_q];
      encChk = bEnc;
    end
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      eeprom_array_ecc_pkg::IDLE: begin
        if (take) begin
          if (reqWrite && !groupedMode) begin
            state_d = eeprom_array_ecc_pkg::MERGE;
          end else begin
            state_d = eeprom_array_ecc_pkg::FETCH;
          end
        end
      end
      eeprom_array_ecc_pkg::FETCH: begin
        if (ackRd) begin
          if (write_q) begin
            state_d = eeprom_array_ecc_pkg::MERGE;
          end else begin
            state_d = eeprom_array_ecc_pkg::IDLE;
          end
        end
      end
      eeprom_array_ecc_pkg::MERGE: begin
        state_d = eeprom_array_ecc_pkg::PROG;
      end
      eeprom_array_ecc_pkg::PROG: begin
        if (ackWr) begin
          state_d = eeprom_array_ecc_pkg::IDLE;
        end
      end
      default: begin
        state_d = eeprom_array_ecc_pkg::IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= eeprom_array_ecc_pkg::IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqReady_q <= 1'b0;
    end else if (ce) begin
      reqReady_q <= (state_d == eeprom_array_ecc_pkg::IDLE);
    end
  end

  // ==========================================================
  // request capture
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_q   <= 1'b0;
      mode_q    <= 1'b0;
      lane_q    <= '0;
      data_q    <= '0;
      arrAddr_q <= '0;
    end else if (ce && take) begin
      write_q   <= reqWrite;
      mode_q    <= groupedMode;
      lane_q    <= reqAddr[`EEA_LANE_W-1:0];
      data_q    <= reqData;
      arrAddr_q <= reqAddr[`EEA_ADDR_W-1:`EEA_LANE_W];
    end
  end

  // ==========================================================
  // row buffer and merge
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      row_q <= `EEA_ROW_RST;
    end else if (ce) begin
      if (state_q == eeprom_array_ecc_pkg::FETCH && ackRd) begin
        row_q <= rowFix;
      end else if (state_q == eeprom_array_ecc_pkg::MERGE) begin
        row_q <= putByte(row_q, lane_q, data_q);
      end
    end
  end

  // ==========================================================
  // array strobes
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arrRdReq_q  <= 1'b0;
      arrWrReq_q  <= 1'b0;
      arrByteEn_q <= `EEA_BE_NONE;
      arrWrData_q <= `EEA_ROW_RST;
      arrWrChk_q  <= `EEA_CHK_RST;
    end else if (ce) begin
      if (take && !(reqWrite && !groupedMode)) begin
        arrRdReq_q <= 1'b1;
      end else if (ackRd) begin
        arrRdReq_q <= 1'b0;
      end
      if (state_q == eeprom_array_ecc_pkg::PROG && !arrWrReq_q) begin
        arrWrReq_q  <= 1'b1;
        arrWrData_q <= row_q;
        arrWrChk_q  <= encChk;
        if (mode_q) begin
          arrByteEn_q <= `EEA_BE_ALL;
        end else begin
          arrByteEn_q <= `EEA_BE_NONE | (`EEA_BYTES'(1) << lane_q);
        end
      end else if (ackWr) begin
        arrWrReq_q  <= 1'b0;
        arrByteEn_q <= `EEA_BE_NONE;
      end
    end
  end

  // ==========================================================
  // read answer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdValid_q   <= 1'b0;
      rdData_q    <= '0;
      corrected_q <= 1'b0;
    end else if (ce) begin
      rdValid_q   <= 1'b0;
      corrected_q <= 1'b0;
      if (state_q == eeprom_array_ecc_pkg::FETCH && ackRd && !write_q) begin
        rdValid_q   <= 1'b1;
        rdData_q    <= pickByte(rowFix, lane_q);
        corrected_q <= rowErr;
      end
    end
  end

endmodule

/* rtl/eeprom_array_ecc_consts.svh */
`ifndef EEPROM_ARRAY_ECC_CONSTS_SVH
`define EEPROM_ARRAY_ECC_CONSTS_SVH

// ==========================================================
// widths
`define EEA_ADDR_W   16
`define EEA_ROW_W    14
`define EEA_LANE_W   2
`define EEA_BYTE_W   8
`define EEA_BYTES    4
`define EEA_DATA_W   32
`define EEA_GCHK_W   6
`define EEA_BCHK_W   4
`define EEA_CHK_W    16

// ==========================================================
// reset values and the all-lanes byte enable
`define EEA_ROW_RST  32'h0000_0000
`define EEA_CHK_RST  16'h0000
`define EEA_BE_ALL   4'hf
`define EEA_BE_NONE  4'h0

`endif

/* rtl/eeprom_array_ecc_pkg.sv */
package eeprom_array_ecc_pkg;

  // ==========================================================
  // sequencer states
  typedef enum logic [1:0] {
    IDLE,
    FETCH,
    MERGE,
    PROG
  } state_t;

endpackage

/* rtl/hamming_sec.sv */
`timescale 1ns/1ps

// single-error-correcting hamming code: encodes data, corrects data against stored check bits
module hamming_sec #(
  parameter int DW = 8,
  parameter int CW = 4
) (
  input  wire logic [DW-1:0] data,
  input  wire logic [CW-1:0] storedCheck,
  output logic      [CW-1:0] check,
  output logic      [DW-1:0] fixedData,
  output logic               error
);

  // ==========================================================
  // code position of data bit i, skipping powers of two
  function automatic logic [CW-1:0] dataPos(input int i);
    int k;
    int hit;
    k = -1;
    hit = 0;
    for (int p = 1; p < 64; p++) begin
      if ((p & (p - 1)) != 0) begin
        k = k + 1;
        if (k == i && hit == 0) begin
          hit = p;
        end
      end
    end
    return CW'(hit);
  endfunction

  // ==========================================================
  // syndrome and correction
  logic [CW-1:0] syndrome;

  always_comb begin
    check = '0;
    for (int i = 0; i < DW; i++) begin
      if (data[i]) begin
        check = check ^ dataPos(i);
      end
    end
    syndrome  = check ^ storedCheck;
    fixedData = data;
    for (int i = 0; i < DW; i++) begin
      if (syndrome == dataPos(i)) begin
        fixedData[i] = ~data[i];
      end
    end
    error = (syndrome != '0);
  end

endmodule

/* verification/eeprom_array_ecc_bench.sv */
`timescale 1ns/1ps
// ==========
// bench
module eeprom_array_ecc_bench;
  logic        clock = 1'h0, rst = 1'h1, ce = 1'h1, groupedMode = 1'h0;
  logic        reqValid = 1'h0, reqWrite = 1'h0;
  logic [15:0] reqAddr = 16'h0, arrWrChk_q, arrRdChk;
  logic [7:0]  reqData = 8'h0, rdData_q;
  logic        reqReady_q, rdValid_q, corrected_q, arrRdReq_q, arrWrReq_q, arrAck;
  logic [13:0] arrAddr_q;
  logic [3:0]  arrByteEn_q;
  logic [31:0] arrWrData_q, arrRdData;
  bit   [7:0]  refMem [0:65535];
  int          nErrors = 0, testsRun = 0;
  eeprom_array_ecc uut (.clock(clock), .rst(rst), .ce(ce), .groupedMode(groupedMode),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqData(reqData),
    .reqReady_q(reqReady_q), .rdValid_q(rdValid_q), .rdData_q(rdData_q),
    .corrected_q(corrected_q), .arrRdReq_q(arrRdReq_q), .arrWrReq_q(arrWrReq_q),
    .arrAddr_q(arrAddr_q), .arrByteEn_q(arrByteEn_q), .arrWrData_q(arrWrData_q),
    .arrWrChk_q(arrWrChk_q), .arrAck(arrAck), .arrRdData(arrRdData), .arrRdChk(arrRdChk));
  eeprom_array_model model (.clock(clock), .arrRdReq_q(arrRdReq_q), .arrWrReq_q(arrWrReq_q),
    .arrAddr_q(arrAddr_q), .arrByteEn_q(arrByteEn_q), .arrWrData_q(arrWrData_q),
    .arrWrChk_q(arrWrChk_q), .arrAck(arrAck), .arrRdData(arrRdData), .arrRdChk(arrRdChk));
  task automatic cmpVal(string nm, logic [47:0] e, logic [47:0] g);
    testsRun++;
    if (g !== e) begin
      nErrors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmpBit(string nm, logic e, logic g);
    cmpVal(nm, {47'h0, e}, {47'h0, g});
  endtask
  function automatic logic [5:0] enc(logic [31:0] d, int dw);
    logic [5:0] c;
    int p, i;
    c = 6'h0;
    p = 1;
    i = 0;
    while (i < dw) begin
      p++;
      if ((p & (p - 1)) != 0) begin
        if (d[i]) c ^= p[5:0];
        i++;
      end
    end
    return c;
  endfunction
  function automatic logic [47:0] expRow(logic [13:0] r, logic g);
    logic [31:0] d;
    logic [15:0] c;
    d = {refMem[{r, 2'h3}], refMem[{r, 2'h2}], refMem[{r, 2'h1}], refMem[{r, 2'h0}]};
    c = {10'h0, enc(d, 32)};
    if (!g) for (int k = 0; k < 4; k++) c[4*k +: 4] = enc({24'h0, d[8*k +: 8]}, 8);
    return {d, c};
  endfunction
  function automatic int pos(logic [15:0] a, int b);
    if (a[15]) return b < 32 ? 16 + b : b - 32;
    return b < 8 ? 16 + 8 * a[1:0] + b : 4 * a[1:0] + b - 8;
  endfunction
  task automatic waitReady;
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (reqReady_q !== 1'h1 && k < 40);
    cmpBit("reqReady", 1'h1, reqReady_q);
  endtask
  task automatic op(logic w, logic [15:0] a, logic [7:0] d, logic c);
    waitReady();
    @(posedge clock);
    groupedMode <= a[15];
    reqValid <= 1'h1;
    reqWrite <= w;
    reqAddr <= a;
    reqData <= d;
    @(posedge clock);
    reqValid <= 1'h0;
    waitReady();
    if (w) begin
      refMem[a] = d;
      cmpVal("row", expRow(a[15:2], a[15]), model.mem[a[15:2]]);
    end else begin
      cmpBit("rdValid", 1'h1, rdValid_q);
      cmpVal("rdData", 48'(refMem[a]), 48'(rdData_q));
      cmpBit("corrected", c, corrected_q);
    end
  endtask
  task automatic closeOut;
    if (nErrors == 0 && testsRun > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    forever #25 clock = ~clock;
  end
  initial begin
    #1000000;
    nErrors++;
    closeOut();
  end
  initial begin
    int s, b;
    logic [15:0] a;
    void'($urandom(54755));
    repeat (16) @(posedge clock);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++) op(1'h1, {i[2], 13'h0, i[1:0]}, 8'(i + 8'h5a), 1'h0);
    repeat (300) begin
      a = {1'($urandom), 11'h0, 4'($urandom)};
      s = $urandom_range(0, 3);
      b = pos(a, $urandom_range(0, a[15] ? 37 : 11));
      if (s >= 2) model.mem[a[15:2]][b] ^= 1'h1;
      op(s == 0 || s == 3, a, 8'($urandom), s == 2);
      if (s == 2) model.mem[a[15:2]][b] ^= 1'h1;
    end
    closeOut();
  end
endmodule
bind eeprom_array_ecc eeprom_array_ecc_sva chk (.clock(clock), .rst(rst), .ce(ce),
  .groupedMode(groupedMode), .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
  .reqReady_q(reqReady_q), .rdValid_q(rdValid_q), .corrected_q(corrected_q),
  .arrRdReq_q(arrRdReq_q), .arrWrReq_q(arrWrReq_q), .arrAddr_q(arrAddr_q),
  .arrByteEn_q(arrByteEn_q), .arrWrChk_q(arrWrChk_q), .arrAck(arrAck));

/* verification/eeprom_array_ecc_sva.sv */
`timescale 1ns/1ps
// ==========
// port checks
module eeprom_array_ecc_sva (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        ce,
  input wire logic        groupedMode,
  input wire logic        reqValid,
  input wire logic        reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic        reqReady_q,
  input wire logic        rdValid_q,
  input wire logic        corrected_q,
  input wire logic        arrRdReq_q,
  input wire logic        arrWrReq_q,
  input wire logic [13:0] arrAddr_q,
  input wire logic [3:0]  arrByteEn_q,
  input wire logic [15:0] arrWrChk_q,
  input wire logic        arrAck
);
  logic        grp_q;
  logic        wr_q;
  logic [15:0] addr_q;
  wire         take = ce && reqValid && reqReady_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      grp_q <= 1'h0;
      wr_q <= 1'h0;
      addr_q <= 16'h0;
    end else if (take) begin
      grp_q <= groupedMode;
      wr_q <= reqWrite;
      addr_q <= reqAddr;
    end
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  read_first_a: assert property (take && (groupedMode || !reqWrite) |=> arrRdReq_q)
    else $error("no array read");
  byte_noread_a: assert property (take && !groupedMode && reqWrite |=> !arrRdReq_q [*4])
    else $error("per-byte write read");
  group_lanes_a: assert property (arrWrReq_q && grp_q |-> arrByteEn_q == 4'hf)
    else $error("group lanes");
  byte_lane_a: assert property (arrWrReq_q && !grp_q |-> arrByteEn_q == 4'h1 << addr_q[1:0])
    else $error("byte lane");
  group_chk_a: assert property (arrWrReq_q && grp_q |-> arrWrChk_q[15:6] == 10'h0)
    else $error("group check width");
  row_addr_a: assert property (arrRdReq_q || arrWrReq_q |-> arrAddr_q == addr_q[15:2])
    else $error("row address");
  read_answer_a: assert property (arrRdReq_q && arrAck && !wr_q |=> rdValid_q && reqReady_q)
    else $error("read answer");
  flag_pulse_a: assert property (corrected_q |-> rdValid_q && !wr_q)
    else $error("stray flag");
  write_done_a: assert property (arrWrReq_q && arrAck |=> reqReady_q && !arrWrReq_q)
    else $error("write not done");
endmodule

/* verification/eeprom_array_model.sv */
`timescale 1ns/1ps
// ==========
// cell array
module eeprom_array_model (
  input  wire logic        clock,
  input  wire logic        arrRdReq_q,
  input  wire logic        arrWrReq_q,
  input  wire logic [13:0] arrAddr_q,
  input  wire logic [3:0]  arrByteEn_q,
  input  wire logic [31:0] arrWrData_q,
  input  wire logic [15:0] arrWrChk_q,
  output logic             arrAck,
  output logic      [31:0] arrRdData,
  output logic      [15:0] arrRdChk
);
  logic [47:0] mem [0:16383];
  int          dly = 0;
  initial begin
    arrAck = 1'h0;
    {arrRdData, arrRdChk} = 48'h0;
    foreach (mem[i]) mem[i] = 48'h0;
  end
  // no cycle limit on any row
  always @(posedge clock) begin
    if ((arrRdReq_q || arrWrReq_q) && !arrAck && dly == 0) begin
      arrAck <= 1'h1;
      dly <= $urandom_range(0, 3);
      {arrRdData, arrRdChk} <= arrRdReq_q ? mem[arrAddr_q] : ~{arrRdData, arrRdChk};
      // check bits kept beside the data
      for (int k = 0; k < 4; k++) begin
        if (arrWrReq_q && arrByteEn_q[k]) begin
          mem[arrAddr_q][16+8*k +: 8] <= arrWrData_q[8*k +: 8];
          mem[arrAddr_q][4*k +: 4] <= arrWrChk_q[4*k +: 4];
        end
      end
    end else begin
      arrAck <= 1'h0;
      dly <= dly > 0 ? dly - 1 : 0;
      {arrRdData, arrRdChk} <= ~{arrRdData, arrRdChk};
    end
  end
endmodule
